// ===== stl_torque_limits.sv
// Operation
// - Four 16-bit limits, two per register
// - Closed loop: high holding, low moving
// - Open loop: high holding, low moving
// - Both registers written from any source; only the host port reads, program and calculation only write
// - New limits active within one servo cycle
// - Register write equals setting both limits of that register
// - One limit changes, others kept
// - Calculation writes only one half
// - Host read returns current register contents
// - Set-all command updates both registers
`default_nettype none
`include "stl_cfg.svh"
module stl_torque_limits
  import stl_pkg::*;
#(
  parameter int unsigned SERVO_CYCLES = `STL_SERVO_CYCLES
)
(
  input wire logic sys_clk_in, // System clock, 125 MHz
  input wire logic rst_n_in, // Async reset, active low
  input wire logic set_all_torque_limits_cmd_in, // Set-all strobe
  input wire logic [`STL_LIM_W-1:0] set_cl_hold_in, // Closed loop holding value
  input wire logic [`STL_LIM_W-1:0] set_cl_move_in, // Closed loop moving value
  input wire logic [`STL_LIM_W-1:0] set_ol_hold_in, // Open loop holding value
  input wire logic [`STL_LIM_W-1:0] set_ol_move_in, // Open loop moving value
  input wire logic host_register_write_cmd_in, // Host write strobe
  input wire logic host_register_read_cmd_in, // Host read strobe
  input wire logic [`STL_ADDR_W-1:0] host_addr_in, // Host register index
  input wire logic [`STL_REG_W-1:0] host_wdata_in, // Host write value
  input wire logic program_register_write_cmd_in, // Program write strobe
  input wire logic [`STL_ADDR_W-1:0] prog_addr_in, // Program register index
  input wire logic [`STL_REG_W-1:0] prog_wdata_in, // Program write value
  input wire logic internal_calculation_cmd_in, // Half-word copy strobe
  input wire logic [`STL_ADDR_W-1:0] calc_addr_in, // Copy target index
  input wire logic calc_half_in, // Copy target half, 1 = high
  output logic [`STL_LIM_W-1:0] act_cl_hold_out, // Active closed loop holding
  output logic [`STL_LIM_W-1:0] act_cl_move_out, // Active closed loop moving
  output logic [`STL_LIM_W-1:0] act_ol_hold_out, // Active open loop holding
  output logic [`STL_LIM_W-1:0] act_ol_move_out, // Active open loop moving
  output logic limits_applied_out, // Pulse when actives reload
  output logic [`STL_REG_W-1:0] host_rdata_out, // Host read value
  output logic host_rvalid_out, // Host read answer pulse
  output logic host_rerr_out // Host read of unmapped index
);

  logic [`STL_REG_W-1:0] cl_lim; // Closed loop limit register
  logic [`STL_REG_W-1:0] ol_lim; // Open loop limit register
  logic [`STL_REG_W-1:0] acc; // Accumulator
  logic [`STL_REG_W-1:0] next_cl_lim;
  logic [`STL_REG_W-1:0] next_ol_lim;
  logic [`STL_REG_W-1:0] next_acc;
  logic [`STL_LIM_W-1:0] next_act_cl_hold;
  logic [`STL_LIM_W-1:0] next_act_cl_move;
  logic [`STL_LIM_W-1:0] next_act_ol_hold;
  logic [`STL_LIM_W-1:0] next_act_ol_move;
  logic next_applied;
  logic [`STL_REG_W-1:0] next_rdata;
  logic next_rvalid;
  logic next_rerr;
  logic servo_tick; // One pulse per servo cycle
  stl_sel_t host_wsel; // Decoded host write target
  stl_sel_t host_rsel; // Decoded host read target
  stl_sel_t prog_sel; // Decoded program write target
  stl_sel_t calc_sel; // Decoded copy target

  // Map an index to a one-hot register select
  function automatic stl_sel_t decode(input logic [`STL_ADDR_W-1:0] addr);
    stl_sel_t sel;
    sel = 3'h0;
    case (addr)
      `STL_ADDR_CL: sel = 3'h1;
      `STL_ADDR_OL: sel = 3'h2;
      `STL_ADDR_ACC: sel = 3'h4;
      default: sel = 3'h0;
    endcase
    return sel;
  endfunction

  // Replace one half of a register, keep the other
  function automatic logic [`STL_REG_W-1:0] merge_half(input logic [`STL_REG_W-1:0] old,
                                                       input logic [`STL_LIM_W-1:0] word,
                                                       input logic high);
    logic [`STL_REG_W-1:0] res;
    res = old;
    if (high)
    begin
      res[`STL_HOLD_HI:`STL_HOLD_LO] = word;
    end
    else
    begin
      res[`STL_MOVE_HI:`STL_MOVE_LO] = word;
    end
    return res;
  endfunction

  assign host_wsel = decode(host_addr_in);
  assign host_rsel = decode(host_addr_in);
  assign prog_sel = decode(prog_addr_in);
  assign calc_sel = decode(calc_addr_in);

  // Servo cycle pacing; actives only move on this pulse
  stl_servo_tick #(
    .CYCLES(SERVO_CYCLES)
  ) u_tick (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .tick_out(servo_tick)
  );

  // Register file updates. Same-cycle writers are applied in a fixed
  // order (set-all, host, program, copy) so the last one stands; values
  // are stored as given, with no percent scaling.
  always_comb
  begin
    next_cl_lim = cl_lim;
    next_ol_lim = ol_lim;
    next_acc = acc;
    if (set_all_torque_limits_cmd_in)
    begin
      next_cl_lim = {set_cl_hold_in, set_cl_move_in};
      next_ol_lim = {set_ol_hold_in, set_ol_move_in};
    end
    if (host_register_write_cmd_in)
    begin
      if (host_wsel[0])
        next_cl_lim = host_wdata_in;
      if (host_wsel[1])
        next_ol_lim = host_wdata_in;
      if (host_wsel[2])
        next_acc = host_wdata_in;
    end
    if (program_register_write_cmd_in)
    begin
      if (prog_sel[0])
        next_cl_lim = prog_wdata_in;
      if (prog_sel[1])
        next_ol_lim = prog_wdata_in;
      if (prog_sel[2])
        next_acc = prog_wdata_in;
    end
    // Half-word copy
    // Copies the accumulator as it stood before this cycle's load
    if (internal_calculation_cmd_in)
    begin
      if (calc_sel[0])
        next_cl_lim = merge_half(next_cl_lim, acc[`STL_MOVE_HI:`STL_MOVE_LO], calc_half_in);
      if (calc_sel[1])
        next_ol_lim = merge_half(next_ol_lim, acc[`STL_MOVE_HI:`STL_MOVE_LO], calc_half_in);
    end
  end

  // Register storage
  // Four packed limits and the accumulator
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cl_lim <= `STL_RST_REG;
      ol_lim <= `STL_RST_REG;
      acc <= `STL_RST_REG;
    end
    else
    begin
      cl_lim <= next_cl_lim;
      ol_lim <= next_ol_lim;
      acc <= next_acc;
    end
  end

  // Active limits reload from the registers once per servo cycle, so a
  // write is in force at most one cycle later whichever path made it
  always_comb
  begin
    next_act_cl_hold = act_cl_hold_out;
    next_act_cl_move = act_cl_move_out;
    next_act_ol_hold = act_ol_hold_out;
    next_act_ol_move = act_ol_move_out;
    next_applied = 1'b0;
    if (servo_tick)
    begin
      next_act_cl_hold = cl_lim[`STL_HOLD_HI:`STL_HOLD_LO];
      next_act_cl_move = cl_lim[`STL_MOVE_HI:`STL_MOVE_LO];
      next_act_ol_hold = ol_lim[`STL_HOLD_HI:`STL_HOLD_LO];
      next_act_ol_move = ol_lim[`STL_MOVE_HI:`STL_MOVE_LO];
      next_applied = 1'b1;
    end
  end

  // Active limit storage
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      act_cl_hold_out <= `STL_RST_LIM;
      act_cl_move_out <= `STL_RST_LIM;
      act_ol_hold_out <= `STL_RST_LIM;
      act_ol_move_out <= `STL_RST_LIM;
      limits_applied_out <= 1'b0;
    end
    else
    begin
      act_cl_hold_out <= next_act_cl_hold;
      act_cl_move_out <= next_act_cl_move;
      act_ol_hold_out <= next_act_ol_hold;
      act_ol_move_out <= next_act_ol_move;
      limits_applied_out <= next_applied;
    end
  end

  // Host read answer, one cycle after the strobe; shows pre-write contents
  always_comb
  begin
    next_rdata = `STL_RST_REG;
    next_rvalid = 1'b0;
    next_rerr = 1'b0;
    if (host_register_read_cmd_in)
    begin
      next_rvalid = 1'b1;
      if (host_rsel[0])
        next_rdata = cl_lim;
      else if (host_rsel[1])
        next_rdata = ol_lim;
      else if (host_rsel[2])
        next_rdata = acc;
      else
        // Unmapped index reads zero with an error flag
        next_rerr = 1'b1;
    end
  end

  // Read answer storage
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      host_rdata_out <= `STL_RST_REG;
      host_rvalid_out <= 1'b0;
      host_rerr_out <= 1'b0;
    end
    else
    begin
      host_rdata_out <= next_rdata;
      host_rvalid_out <= next_rvalid;
      host_rerr_out <= next_rerr;
    end
  end

  property p_host_write_cl;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (host_register_write_cmd_in && host_addr_in == `STL_ADDR_CL && !program_register_write_cmd_in &&
     !internal_calculation_cmd_in) |=> (cl_lim == $past(host_wdata_in));
  endproperty
  a_host_write_cl: assert property (p_host_write_cl) else $error("host write to closed loop lost");

  property p_other_kept;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (host_register_write_cmd_in && host_addr_in == `STL_ADDR_CL && !set_all_torque_limits_cmd_in &&
     !program_register_write_cmd_in && !internal_calculation_cmd_in) |=> $stable(ol_lim);
  endproperty
  a_other_kept: assert property (p_other_kept) else $error("open loop changed by closed loop write");

  property p_half_copy;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (internal_calculation_cmd_in && calc_addr_in == `STL_ADDR_OL && calc_half_in &&
     !host_register_write_cmd_in && !program_register_write_cmd_in && !set_all_torque_limits_cmd_in)
    |=> (ol_lim[`STL_HOLD_HI:`STL_HOLD_LO] == $past(acc[`STL_MOVE_HI:`STL_MOVE_LO])) &&
        (ol_lim[`STL_MOVE_HI:`STL_MOVE_LO] == $past(ol_lim[`STL_MOVE_HI:`STL_MOVE_LO]));
  endproperty
  a_half_copy: assert property (p_half_copy) else $error("half copy disturbed other half");

  property p_set_all;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (set_all_torque_limits_cmd_in && !host_register_write_cmd_in && !program_register_write_cmd_in &&
     !internal_calculation_cmd_in)
    |=> (cl_lim == {$past(set_cl_hold_in), $past(set_cl_move_in)}) &&
        (ol_lim == {$past(set_ol_hold_in), $past(set_ol_move_in)});
  endproperty
  a_set_all: assert property (p_set_all) else $error("set-all did not fill both registers");

  property p_apply_fields;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    servo_tick |=> limits_applied_out && (act_cl_hold_out == $past(cl_lim[`STL_HOLD_HI:`STL_HOLD_LO])) &&
                   (act_cl_move_out == $past(cl_lim[`STL_MOVE_HI:`STL_MOVE_LO])) &&
                   (act_ol_hold_out == $past(ol_lim[`STL_HOLD_HI:`STL_HOLD_LO])) &&
                   (act_ol_move_out == $past(ol_lim[`STL_MOVE_HI:`STL_MOVE_LO]));
  endproperty
  a_apply_fields: assert property (p_apply_fields) else $error("active limits not taken from registers");

  property p_read_back;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (host_register_read_cmd_in && host_addr_in == `STL_ADDR_OL)
    |=> host_rvalid_out && !host_rerr_out && (host_rdata_out == $past(ol_lim));
  endproperty
  a_read_back: assert property (p_read_back) else $error("host read returned wrong contents");

  property p_later_wins;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (host_register_write_cmd_in && host_addr_in == `STL_ADDR_CL) ##1
    (program_register_write_cmd_in && prog_addr_in == `STL_ADDR_CL && !internal_calculation_cmd_in)
    |=> (cl_lim == $past(prog_wdata_in));
  endproperty
  a_later_wins: assert property (p_later_wins) else $error("earlier write overrode later one");

  property p_actives_hold;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    !servo_tick |=> !limits_applied_out && $stable(act_cl_move_out) && $stable(act_ol_hold_out);
  endproperty
  a_actives_hold: assert property (p_actives_hold) else $error("actives moved off the servo tick");

endmodule
`default_nettype wire

// ===== stl_cfg.svh
`ifndef STL_CFG_SVH
`define STL_CFG_SVH

// Register index space seen by the command ports
`define STL_ADDR_W 8
`define STL_ADDR_ACC 8'h0a
`define STL_ADDR_CL 8'hce
`define STL_ADDR_OL 8'hcf

// Field layout of a limit register
`define STL_LIM_W 16
`define STL_REG_W 32
`define STL_HOLD_HI 31
`define STL_HOLD_LO 16
`define STL_MOVE_HI 15
`define STL_MOVE_LO 0

// Reset contents
`define STL_RST_REG 32'h0000_0000
`define STL_RST_LIM 16'h0000

// Timing: clock period and servo cycle, both in ns
`define STL_CLK_PERIOD_NS 8
`define STL_SERVO_CYCLE_NS 120000
`define STL_SERVO_CYCLES (`STL_SERVO_CYCLE_NS / `STL_CLK_PERIOD_NS)
`define STL_TICK_W 16

`endif

// ===== stl_pkg.sv
`default_nettype none
package stl_pkg;
  // Which half of a limit register a calculation copy lands in
  typedef enum logic {
    STL_HALF_LOW = 1'b0,
    STL_HALF_HIGH = 1'b1
  } stl_half_t;
  // One-hot register select {acc, open loop, closed loop}
  typedef logic [2:0] stl_sel_t;
endpackage
`default_nettype wire

// ===== stl_servo_tick.sv
`default_nettype none
`include "stl_cfg.svh"
module stl_servo_tick
  import stl_pkg::*;
#(
  parameter int unsigned CYCLES = `STL_SERVO_CYCLES
)
(
  input wire logic sys_clk_in, // System clock
  input wire logic rst_n_in, // Async reset, active low
  output logic tick_out // One pulse per servo cycle
);

  logic [`STL_TICK_W-1:0] count; // Cycles left in this servo cycle
  logic [`STL_TICK_W-1:0] next_count;
  logic next_tick;

  // Count down and fire on reaching zero
  always_comb
  begin
    next_tick = 1'b0;
    if (count == '0)
    begin
      next_count = `STL_TICK_W'(CYCLES - 1);
      next_tick = 1'b1;
    end
    else
    begin
      next_count = count - `STL_TICK_W'(1);
    end
  end

  // Register the divider
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count <= '0;
      tick_out <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick_out <= next_tick;
    end
  end

  // Checker helper: cycles since the last pulse, counted apart from the
  // divider so a wrong reload value cannot hide behind it
  logic [`STL_TICK_W-1:0] gap_cnt;
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      gap_cnt <= '0;
    end
    else if (tick_out)
    begin
      gap_cnt <= '0;
    end
    else
    begin
      gap_cnt <= gap_cnt + `STL_TICK_W'(1);
    end
  end

  property p_tick_gap;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    gap_cnt <= `STL_TICK_W'(CYCLES - 1);
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("servo cycle longer than allowed");

endmodule
`default_nettype wire

// ===== stl_host_model.sv
`default_nettype none
module stl_host_model
(
  input wire logic sys_clk_in, // System clock
  output logic wr_out, // Host write strobe
  output logic rd_out, // Host read strobe
  output logic [7:0] addr_out, // Register index
  output logic [31:0] wdata_out, // Write value
  input wire logic [31:0] rdata_in, // Read value
  input wire logic rvalid_in, // Read answer pulse
  input wire logic rerr_in // Unmapped read flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle host at time zero
  initial
  begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 32'h0000_0000;
  end

  task automatic write(input logic [7:0] a, input logic [31:0] d);
    @(negedge sys_clk_in);
    wr_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(negedge sys_clk_in);
    wr_out = 1'b0;
    // Released lines flip so a stale value is never mistaken for a request
    addr_out = ~a;
    wdata_out = ~d;
  endtask

  // Read waits a bounded time for the one-cycle answer
  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic e);
    int n;
    n = 0;
    @(negedge sys_clk_in);
    rd_out = 1'b1;
    addr_out = a;
    @(negedge sys_clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    while (rvalid_in !== 1'b1 && n < 4)
    begin
      @(negedge sys_clk_in);
      n++;
    end
    d = (rvalid_in === 1'b1) ? rdata_in : 32'hxxxx_xxxx;
    e = rerr_in;
  endtask
endmodule
`default_nettype wire

// ===== stl_torque_limits_bench.sv
`default_nettype none
module stl_torque_limits_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Short servo cycle keeps the run brief
  localparam int unsigned SC = 8;
  logic sys_clk_in = 1'b0; // Bench clock
  logic rst_n_in = 1'b0; // Reset, active low
  logic set_cmd = 1'b0; // Set-all strobe
  logic [15:0] s_clh = 16'h0000, s_clm = 16'h0000, s_olh = 16'h0000, s_olm = 16'h0000; // Set-all values
  logic prog_cmd = 1'b0; // Program write strobe
  logic [7:0] prog_addr = 8'h00; // Program index
  logic [31:0] prog_wdata = 32'h0000_0000; // Program value
  logic calc_cmd = 1'b0; // Half copy strobe
  logic [7:0] calc_addr = 8'h00; // Copy target
  logic calc_half = 1'b0; // Copy half
  wire logic hw, hr, rvalid, rerr, applied; // Host strobes and answers
  wire logic [7:0] haddr; // Host index
  wire logic [31:0] hwdata, rdata; // Host data
  wire logic [15:0] a_clh, a_clm, a_olh, a_olm; // Active limits
  int bad_count = 0, tests_run = 0, cyc = 0, n_app = 0; // Counters
  logic [31:0] seed = 32'h3d9d, e_cl = 32'h0000_0000, e_ol = 32'h0000_0000, e_acc = 32'h0000_0000, v; // Model
  logic [31:0] rd; // Read result
  logic er; // Read error

  always #4 sys_clk_in = ~sys_clk_in;

  stl_torque_limits #(.SERVO_CYCLES(SC)) stl_torque_limits_inst (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .set_all_torque_limits_cmd_in(set_cmd), .set_cl_hold_in(s_clh), .set_cl_move_in(s_clm),
    .set_ol_hold_in(s_olh), .set_ol_move_in(s_olm),
    .host_register_write_cmd_in(hw), .host_register_read_cmd_in(hr), .host_addr_in(haddr),
    .host_wdata_in(hwdata), .program_register_write_cmd_in(prog_cmd), .prog_addr_in(prog_addr),
    .prog_wdata_in(prog_wdata), .internal_calculation_cmd_in(calc_cmd), .calc_addr_in(calc_addr),
    .calc_half_in(calc_half), .act_cl_hold_out(a_clh), .act_cl_move_out(a_clm), .act_ol_hold_out(a_olh),
    .act_ol_move_out(a_olm), .limits_applied_out(applied), .host_rdata_out(rdata),
    .host_rvalid_out(rvalid), .host_rerr_out(rerr));

  stl_host_model stl_host_model_inst (
    .sys_clk_in(sys_clk_in), .wr_out(hw), .rd_out(hr), .addr_out(haddr), .wdata_out(hwdata),
    .rdata_in(rdata), .rvalid_in(rvalid), .rerr_in(rerr));

  // Cycle count cuts a hang short and counts apply pulses
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (applied === 1'b1)
      n_app++;
    if (cyc == 6000)
    begin
      bad_count++;
      test_done();
    end
  end

  // Galois shift register for repeatable values
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0400_0007 : 32'h0000_0000);
  endfunction

  // Expected word after a half copy
  function automatic logic [31:0] put_half(input logic [31:0] w, input logic [15:0] h, input logic hi);
    return hi ? {h, w[15:0]} : {w[31:16], h};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    stl_host_model_inst.read(a, rd, er);
    check("rdata", rd, exp);
    check("rerr", {31'h0, er}, {31'h0, experr});
  endtask

  task automatic prog_write(input logic [7:0] a, input logic [31:0] d);
    @(negedge sys_clk_in);
    prog_cmd = 1'b1;
    prog_addr = a;
    prog_wdata = d;
    @(negedge sys_clk_in);
    prog_cmd = 1'b0;
    prog_wdata = ~d;
  endtask

  task automatic calc(input logic [7:0] a, input logic hi);
    @(negedge sys_clk_in);
    calc_cmd = 1'b1;
    calc_addr = a;
    calc_half = hi;
    @(negedge sys_clk_in);
    calc_cmd = 1'b0;
  endtask

  // One tick per window, then actives must match the registers
  task automatic act_check();
    n_app = 0;
    repeat (SC) @(negedge sys_clk_in);
    check("applied", n_app, 1);
    repeat (2) @(negedge sys_clk_in);
    check("cl_hold", {16'h0, a_clh}, {16'h0, e_cl[31:16]});
    check("cl_move", {16'h0, a_clm}, {16'h0, e_cl[15:0]});
    check("ol_hold", {16'h0, a_olh}, {16'h0, e_ol[31:16]});
    check("ol_move", {16'h0, a_olm}, {16'h0, e_ol[15:0]});
  endtask

  initial
  begin
    repeat (16) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    rdchk(8'hce, 32'h0, 1'b0);
    rdchk(8'hcf, 32'h0, 1'b0);
    act_check();
    $display("test reset done");
    // Random host words, including an all-ones full-scale word
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      v = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0fa0_4e20 : seed;
      stl_host_model_inst.write(i[0] ? 8'hcf : 8'hce, v);
      if (i[0])
        e_ol = v;
      else
        e_cl = v;
      rdchk(i[0] ? 8'hcf : 8'hce, v, 1'b0);
      act_check();
    end
    $display("test host write done");
    seed = lfsr(seed);
    e_acc = seed;
    prog_write(8'h0a, e_acc);
    calc(8'hce, 1'b0);
    calc(8'hcf, 1'b1);
    calc(8'h55, 1'b1);
    e_cl = put_half(e_cl, e_acc[15:0], 1'b0);
    e_ol = put_half(e_ol, e_acc[15:0], 1'b1);
    rdchk(8'hce, e_cl, 1'b0);
    rdchk(8'hcf, e_ol, 1'b0);
    rdchk(8'h0a, e_acc, 1'b0);
    act_check();
    $display("test half copy done");
    // Set-all loads both registers
    seed = lfsr(seed);
    @(negedge sys_clk_in);
    set_cmd = 1'b1;
    {s_clh, s_clm} = seed;
    {s_olh, s_olm} = ~seed;
    @(negedge sys_clk_in);
    set_cmd = 1'b0;
    e_cl = seed;
    e_ol = ~seed;
    rdchk(8'hce, e_cl, 1'b0);
    rdchk(8'hcf, e_ol, 1'b0);
    act_check();
    $display("test set all done");
    // Unmapped index is refused
    stl_host_model_inst.write(8'h55, seed);
    rdchk(8'h55, 32'h0, 1'b1);
    rdchk(8'hce, e_cl, 1'b0);
    $display("test unmapped done");
    // Same-cycle host and program writes, program is applied later
    seed = lfsr(seed);
    fork
      stl_host_model_inst.write(8'hce, ~seed);
      prog_write(8'hce, seed);
    join
    e_cl = seed;
    rdchk(8'hce, e_cl, 1'b0);
    // Program then host with one idle cycle between, host is later
    prog_write(8'hcf, seed);
    stl_host_model_inst.write(8'hcf, ~seed);
    e_ol = ~seed;
    rdchk(8'hcf, e_ol, 1'b0);
    // Host then program on consecutive cycles, program is later
    seed = lfsr(seed);
    fork
      stl_host_model_inst.write(8'hce, ~seed);
      begin
        @(negedge sys_clk_in);
        prog_write(8'hce, seed);
      end
    join
    e_cl = seed;
    rdchk(8'hce, e_cl, 1'b0);
    act_check();
    $display("test close writes done");
    test_done();
  end
endmodule
`default_nettype wire
